/* File: core/dtw_pkg.sv */
package dtw_pkg;
	// ==========================================================
	// clock and time bases
	localparam int CLK_PERIOD_NS = 4;
	localparam int TB_60_NS = 60;
	localparam int TB_100_NS = 100;
	localparam int TB_1US_NS = 1000;
	localparam int TB_1MS_NS = 1000000;
	localparam int TB_60_CYC = TB_60_NS / CLK_PERIOD_NS;
	localparam int TB_100_CYC = TB_100_NS / CLK_PERIOD_NS;
	localparam int TB_1US_CYC = TB_1US_NS / CLK_PERIOD_NS;
	localparam int TB_1MS_CYC = TB_1MS_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 18;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_T0_CTRL = 8'h00;
	localparam logic [7:0] OFS_T0_STAT = 8'h04;
	localparam logic [7:0] OFS_T1_CTRL = 8'h08;
	localparam logic [7:0] OFS_T1_STAT = 8'h0c;
	localparam logic [7:0] OFS_G_CTRL = 8'h10;
	localparam logic [7:0] OFS_G_STAT = 8'h14;
	localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
	localparam logic [1:0] SAFE_PAGE = 2'h1;

	// ==========================================================
	// field positions
	localparam int BIT_EXPIRED = 29;
	localparam int BIT_EN = 28;
	localparam int BIT_RUN = 28;
	localparam int BIT_MODE = 25;
	localparam int BIT_SAFE_EN = 25;
	localparam int BIT_IE = 24;
	localparam int BIT_G_EXPIRED = 20;
	localparam int TB_LSB = 16;
	localparam int TB_MSB = 17;
	localparam int CNT_W = 16;
	localparam int BIT_GIS_GUARD = 8;
	localparam int BIT_GIS_T0 = 9;
	localparam int BIT_GIS_T1 = 10;
	localparam int BIT_ACK_STYLE = 0;
	localparam logic [31:0] CTRL_MASK = 32'h1303ffff;
	localparam logic [31:0] G_CTRL_MASK = 32'h1303ffff;

	// ==========================================================
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] GLOBAL_CONTROL_RST = 32'h00000000;
	localparam logic [7:0] SAFE_RST = 8'h00;
	localparam int SAFE_PORTS = 16;
	localparam int SAFE_BITS = 8;

	typedef enum logic {
		DTW_ACK_ON_READ,
		DTW_ACK_ON_WRITE
	} dtw_ack_t;
endpackage

/* File: core/dtw_safe_mem.sv */
`timescale 1ns/1ps
module dtw_safe_mem import dtw_pkg::*; #(
	parameter int DEPTH = SAFE_PORTS,
	parameter int WIDTH = SAFE_BITS
)(
	input wire logic clock,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data,
	output logic [DEPTH*WIDTH-1:0] all_data
);
	if (DEPTH < 2 || WIDTH != SAFE_BITS) begin : g_chk
		$error("dtw_safe_mem: unsupported geometry");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [WIDTH-1:0] rd_nxt;

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (wr_en) begin
			mem_nxt[wr_idx] = wr_data;
		end
		// read data is zero outside the read cycle so it stands one cycle only
		rd_nxt = rd_en ? mem_r[rd_idx] : '0;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= SAFE_RST; // R19
			end
			rd_data <= '0;
		end else begin
			mem_r <= mem_nxt;
			rd_data <= rd_nxt;
		end
	end

	for (genvar i = 0; i < DEPTH; i++) begin : g_flat
		assign all_data[i*WIDTH +: WIDTH] = mem_r[i];
	end
endmodule

/* File: core/dtw_top.sv */
`timescale 1ns/1ps
// How it works
// R1 - each timer counts only while its control enable bit 28 is set
// R2 - bit 25 picks single-cycle or continuous; status bit 25 echoes it
// R3 - timer expiry raises an interrupt only when bit 24 is set
// R4 - bits 17:16 pick 100 ns, 1 us or 1 ms count ticks
// R5 - reserved time-base code makes a timer tick every 60 ns
// R6 - bits 15:0 hold the start value, counted in selected ticks
// R7 - software restarts a single-cycle timer by clearing then setting enable
// R8 - status bit 29 flags expiry; cleared per the acknowledge style
// R9 - status bit 28 shows whether the timer is running
// R10 - status echoes interrupt enable at 24 and time base at 17:16
// R11 - status bits 15:0 give the remaining count when read
// R12 - with ack on read, software reads status only inside its handler
// R13 - guard runs only while its control bit 28 is set
// R14 - on guard expiry with bit 25 set, outputs take the safe values
// R15 - guard expiry raises an interrupt only when bit 24 is set
// R16 - guard time base 00/01/10 gives 100 ns/1 us/1 ms, 11 gives 60 ns
// R17 - guard control bits 15:0 give its start count in ticks
// R18 - any access to the guard status register reloads the guard count
// R19 - sixteen 8-bit safe data registers reset to zero
// R20 - global irq status shows timer 0, timer 1, guard at bits 9, 10, 8
// R21 - running timer decrements per tick, expires at zero, reloads or stops
// R22 - reserved bits read zero and all fields reset to zero
module dtw_top import dtw_pkg::*; #(
	parameter int MS_CYCLES = TB_1MS_CYC
)(
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [127:0] port_data,
	output logic [127:0] port_drive,
	output logic [1:0] timer_irq,
	output logic guard_irq,
	output logic guard_expired
);
	if (MS_CYCLES < 2 || MS_CYCLES >= (1 << DIV_W)) begin : g_chk
		$error("dtw_top: MS_CYCLES out of range");
	end

	// ==========================================================
	// tick dividers, free running; tick[0..3] = 60ns, 100ns, 1us, 1ms
	localparam int PER [4] = '{TB_60_CYC, TB_100_CYC, TB_1US_CYC, MS_CYCLES};
	logic [3:0] tick;

	for (genvar d = 0; d < 4; d++) begin : g_div
		logic [DIV_W-1:0] div_r;
		logic [DIV_W-1:0] div_nxt;
		always_comb begin
			if (div_r == DIV_W'(PER[d] - 1)) begin
				div_nxt = '0;
			end else begin
				div_nxt = div_r + 1'b1;
			end
		end
		always_ff @(posedge clock) begin
			if (srst) begin
				div_r <= '0;
			end else begin
				div_r <= div_nxt;
			end
		end
		assign tick[d] = (div_r == DIV_W'(PER[d] - 1));
	end

	// free-running bases mean the first tick after a start is early by up to one
	// period; the trade keeps four dividers instead of one per counter
	function automatic logic tick_of(input logic [1:0] sel, input logic [3:0] t);
		unique case (sel)
			2'b00: tick_of = t[1]; // R4
			2'b01: tick_of = t[2]; // R4
			2'b10: tick_of = t[3]; // R4
			2'b11: tick_of = t[0]; // R5 R16
		endcase
	endfunction

	// ==========================================================
	// global control and decode
	logic [31:0] gctl_r;
	logic [31:0] gctl_nxt;
	logic ack_write;
	logic g_stat_hit;
	logic g_stat_rd;

	assign ack_write = (gctl_r[BIT_ACK_STYLE] == DTW_ACK_ON_WRITE);
	assign g_stat_hit = (addr == OFS_G_STAT);
	assign g_stat_rd = rd && g_stat_hit;

	always_comb begin
		gctl_nxt = gctl_r;
		if (wr && addr == OFS_GLOBAL_CONTROL) begin
			gctl_nxt = {31'h0, wdata[BIT_ACK_STYLE]};
		end
	end

	// ==========================================================
	// two timers
	localparam logic [7:0] TC_OFS [2] = '{OFS_T0_CTRL, OFS_T1_CTRL};
	localparam logic [7:0] TS_OFS [2] = '{OFS_T0_STAT, OFS_T1_STAT};
	logic [31:0] tctl_r [2];
	logic [31:0] tctl_nxt [2];
	logic [CNT_W-1:0] tcnt_r [2];
	logic [CNT_W-1:0] tcnt_nxt [2];
	logic [1:0] trun_r;
	logic [1:0] trun_nxt;
	logic [1:0] ten_d_r;
	logic [1:0] texp_r;
	logic [1:0] texp_nxt;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			logic set;
			logic clr;
			set = 1'b0;
			clr = 1'b0;
			tctl_nxt[i] = tctl_r[i];
			if (wr && addr == TC_OFS[i]) begin
				tctl_nxt[i] = wdata & CTRL_MASK; // R22
			end
			trun_nxt[i] = trun_r[i];
			tcnt_nxt[i] = tcnt_r[i];
			if (!tctl_r[i][BIT_EN]) begin
				trun_nxt[i] = 1'b0; // R1
			end else if (!ten_d_r[i]) begin
				// rising enable is the only start, hence disable-then-enable
				trun_nxt[i] = 1'b1; // R7
				tcnt_nxt[i] = tctl_r[i][CNT_W-1:0]; // R6
			end else if (trun_r[i] && tick_of(tctl_r[i][TB_MSB:TB_LSB], tick)) begin
				if (tcnt_r[i] <= 16'h0001) begin
					set = 1'b1; // R21
					if (tctl_r[i][BIT_MODE]) begin
						tcnt_nxt[i] = tctl_r[i][CNT_W-1:0]; // R2
					end else begin
						trun_nxt[i] = 1'b0; // R2
						tcnt_nxt[i] = '0;
					end
				end else begin
					tcnt_nxt[i] = tcnt_r[i] - 1'b1; // R21
				end
			end
			if (ack_write) begin
				clr = wr && addr == TS_OFS[i] && wdata[BIT_EXPIRED];
			end else begin
				clr = rd && addr == TS_OFS[i];
			end
			// a new expiry in the clearing cycle survives
			texp_nxt[i] = set | (texp_r[i] & ~clr); // R8
		end
	end

	function automatic logic [31:0] tstat(input logic [31:0] c, input logic e,
			input logic r, input logic [CNT_W-1:0] n);
		tstat = 32'h0; // R22
		tstat[BIT_EXPIRED] = e; // R8
		tstat[BIT_RUN] = r; // R9
		tstat[BIT_MODE] = c[BIT_MODE]; // R2
		tstat[BIT_IE] = c[BIT_IE]; // R10
		tstat[TB_MSB:TB_LSB] = c[TB_MSB:TB_LSB]; // R10
		tstat[CNT_W-1:0] = n; // R11
	endfunction

	// ==========================================================
	// guard timer
	logic [31:0] wctl_r;
	logic [31:0] wctl_nxt;
	logic [CNT_W-1:0] wcnt_r;
	logic [CNT_W-1:0] wcnt_nxt;
	logic wen_d_r;
	logic wexp_r;
	logic wexp_nxt;
	logic wirq_r;
	logic wirq_nxt;

	always_comb begin
		logic set;
		logic clr;
		logic guard_enable;
		set = 1'b0;
		clr = 1'b0;
		guard_enable = wctl_r[BIT_EN];
		wctl_nxt = wctl_r;
		if (wr && addr == OFS_G_CTRL) begin
			wctl_nxt = wdata & G_CTRL_MASK; // R22
		end
		wcnt_nxt = wcnt_r;
		wexp_nxt = wexp_r;
		if (!guard_enable) begin
			wexp_nxt = 1'b0; // R13
		end else if (!wen_d_r || ((rd || wr) && g_stat_hit)) begin
			wcnt_nxt = wctl_r[CNT_W-1:0]; // R17 R18
			wexp_nxt = 1'b0;
		end else if (!wexp_r && tick_of(wctl_r[TB_MSB:TB_LSB], tick)) begin
			if (wcnt_r <= 16'h0001) begin
				wcnt_nxt = '0;
				wexp_nxt = 1'b1;
				set = wctl_r[BIT_IE]; // R15
			end else begin
				wcnt_nxt = wcnt_r - 1'b1; // R13
			end
		end
		if (ack_write) begin
			clr = wr && g_stat_hit && wdata[BIT_IE];
		end else begin
			clr = g_stat_rd;
		end
		wirq_nxt = set | (wirq_r & ~clr);
	end

	// ==========================================================
	// safe output data and output drive
	logic [127:0] safe_vec;
	logic [7:0] safe_rd;
	logic safe_wr;
	logic safe_rdy;
	logic safe_sel_r;
	logic [127:0] drive_nxt;

	assign safe_wr = wr && addr[7:6] == SAFE_PAGE;
	assign safe_rdy = rd && addr[7:6] == SAFE_PAGE;

	dtw_safe_mem #(
		.DEPTH(SAFE_PORTS),
		.WIDTH(SAFE_BITS)
	) u_safe (
		.clock(clock),
		.srst(srst),
		.wr_en(safe_wr),
		.wr_idx(addr[5:2]),
		.wr_data(wdata[7:0]),
		.rd_en(safe_rdy),
		.rd_idx(addr[5:2]),
		.rd_data(safe_rd),
		.all_data(safe_vec)
	);

	always_comb begin
		// with the enable clear the pass-through stays, expiry or not
		if (wexp_r && wctl_r[BIT_SAFE_EN]) begin
			drive_nxt = safe_vec; // R14
		end else begin
			drive_nxt = port_data; // R14
		end
	end

	// ==========================================================
	// register read
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [31:0] irq_stat;

	always_comb begin
		irq_stat = 32'h0;
		irq_stat[BIT_GIS_T0] = texp_r[0] & tctl_r[0][BIT_IE]; // R20
		irq_stat[BIT_GIS_T1] = texp_r[1] & tctl_r[1][BIT_IE]; // R20
		irq_stat[BIT_GIS_GUARD] = wirq_r; // R20
		rdata_nxt = 32'h0;
		if (rd) begin
			unique case (addr)
				OFS_T0_CTRL: rdata_nxt = tctl_r[0];
				OFS_T1_CTRL: rdata_nxt = tctl_r[1];
				OFS_T0_STAT: rdata_nxt = tstat(tctl_r[0], texp_r[0], trun_r[0], tcnt_r[0]);
				OFS_T1_STAT: rdata_nxt = tstat(tctl_r[1], texp_r[1], trun_r[1], tcnt_r[1]);
				OFS_G_CTRL: rdata_nxt = wctl_r;
				OFS_G_STAT: begin
					rdata_nxt[BIT_EN] = wctl_r[BIT_EN];
					rdata_nxt[BIT_SAFE_EN] = wctl_r[BIT_SAFE_EN];
					rdata_nxt[BIT_IE] = wirq_r;
					rdata_nxt[BIT_G_EXPIRED] = wexp_r;
					rdata_nxt[TB_MSB:TB_LSB] = wctl_r[TB_MSB:TB_LSB];
					rdata_nxt[CNT_W-1:0] = wcnt_r;
				end
				OFS_GLOBAL_CONTROL: rdata_nxt = gctl_r;
				OFS_IRQ_STAT: rdata_nxt = irq_stat;
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	assign rdata = safe_sel_r ? {24'h0, safe_rd} : rdata_r;

	// ==========================================================
	// state registers
	always_ff @(posedge clock) begin
		if (srst) begin
			gctl_r <= GLOBAL_CONTROL_RST;
			tctl_r[0] <= CTRL_RST; // R22
			tctl_r[1] <= CTRL_RST; // R22
			tcnt_r[0] <= '0;
			tcnt_r[1] <= '0;
			trun_r <= '0;
			ten_d_r <= '0;
			texp_r <= '0;
			wctl_r <= CTRL_RST; // R22
			wcnt_r <= '0;
			wen_d_r <= 1'b0;
			wexp_r <= 1'b0;
			wirq_r <= 1'b0;
			rdata_r <= '0;
			safe_sel_r <= 1'b0;
			port_drive <= '0;
		end else begin
			gctl_r <= gctl_nxt;
			tctl_r <= tctl_nxt;
			tcnt_r <= tcnt_nxt;
			trun_r <= trun_nxt;
			ten_d_r <= {tctl_r[1][BIT_EN], tctl_r[0][BIT_EN]};
			texp_r <= texp_nxt;
			wctl_r <= wctl_nxt;
			wcnt_r <= wcnt_nxt;
			wen_d_r <= wctl_r[BIT_EN];
			wexp_r <= wexp_nxt;
			wirq_r <= wirq_nxt;
			rdata_r <= rdata_nxt;
			safe_sel_r <= safe_rdy;
			port_drive <= drive_nxt;
		end
	end

	assign timer_irq = {texp_r[1] & tctl_r[1][BIT_IE], texp_r[0] & tctl_r[0][BIT_IE]}; // R3
	assign guard_irq = wirq_r; // R15
	assign guard_expired = wexp_r;
endmodule

/* File: tb/dtw_checker.sv */
`timescale 1ns/1ps
module dtw_checker import dtw_pkg::*; #(
	parameter int MS_CYCLES = TB_1MS_CYC
)(
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [127:0] port_data,
	input wire logic [127:0] port_drive,
	input wire logic [1:0] timer_irq,
	input wire logic guard_irq,
	input wire logic guard_expired
);
	// ==========================================================
	// bus answer and flag relations
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_unmapped_reads_zero: assert property ($past(rd) && $past(addr) == 8'h30 |-> rdata == 32'h0)
		else $error("unmapped read returned data");
	a_port_pass_through: assert property (
		!$past(srst) && !$past(guard_expired) |-> port_drive == $past(port_data))
		else $error("port drive differs from delayed port data");
	a_guard_irq_cause: assert property ($rose(guard_irq) |-> guard_expired)
		else $error("guard irq rose without expiry");
	// a disable clears expiry one cycle after its write, a retrigger in the access cycle
	a_guard_exp_release: assert property (
		$fell(guard_expired) |-> $past(wr) || $past(rd) || $past(wr, 2))
		else $error("guard expiry left without an access");
	a_guard_exp_holds: assert property (
		guard_expired && !rd && !wr && !$past(wr) |=> guard_expired)
		else $error("guard expiry dropped by itself");
	a_guard_irq_holds: assert property (guard_irq && !rd && !wr |=> guard_irq)
		else $error("guard irq dropped by itself");
	a_timer_irq_holds: assert property (
		!rd && !wr |=> (timer_irq & $past(timer_irq)) == $past(timer_irq))
		else $error("timer irq dropped by itself");
endmodule

/* File: tb/dtw_host.sv */
`timescale 1ns/1ps
module dtw_host(
	input wire logic clock,
	input wire logic [31:0] rdata,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd
);
	// ==========================================================
	// register bus master
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		// stale data would hide a design that samples late
		wdata <= ~d;
	endtask

	// ack-on-read status reads come only where no expired flag is set or where one is meant to be consumed
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// single-cycle timers only restart on a fresh enable
	task automatic restart(input logic [7:0] a, input logic [31:0] d);
		wr_reg(a, 32'h0);
		wr_reg(a, d);
	endtask
endmodule

/* File: tb/dtw_tb_top.sv */
`timescale 1ns/1ps
module dtw_tb_top import dtw_pkg::*;;
	localparam int MS = 40;
	localparam logic [127:0] PD = 128'h00112233445566778899aabbccddeeff;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [127:0] port_data = PD;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic wr, rd, guard_irq, guard_expired;
	logic [127:0] port_drive;
	logic [1:0] timer_irq;
	int err_count = 0;
	int checks_done = 0;
	int per[4] = '{25, 250, MS, 15};
	int i, c;

	always #2 clock = ~clock;

	dtw_top #(.MS_CYCLES(MS)) DUT (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .port_data(port_data), .port_drive(port_drive),
		.timer_irq(timer_irq), .guard_irq(guard_irq), .guard_expired(guard_expired));
	dtw_host HOST (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	// ==========================================================
	// compare and report
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		HOST.rd_reg(a, d);
		chk(d & m, e);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		HOST.wr_reg(8'h30, 32'hffffffff);
		for (i = 0; i < 8; i++) rchk(8'(4 * i), 32'h0, 32'hffffffff);
		for (i = 0; i < 16; i++) rchk(8'(8'h40 + 4 * i), 32'h0, 32'hffffffff);
		rchk(8'h30, 32'h0, 32'hffffffff);
		HOST.wr_reg(OFS_T1_CTRL, 32'hffffffff);
		rchk(OFS_T1_CTRL, CTRL_MASK, 32'hffffffff);
		HOST.wr_reg(OFS_T1_CTRL, 32'h0);
		HOST.wr_reg(OFS_G_CTRL, 32'hffffffff);
		rchk(OFS_G_CTRL, G_CTRL_MASK, 32'hffffffff);
		HOST.wr_reg(OFS_G_CTRL, 32'h0);
		$display("test reset done");
		// every tick code, single-cycle, start 3
		for (c = 0; c < 4; c++) begin
			HOST.restart(OFS_T0_CTRL, 32'h11000003 | (32'(c) << 16));
			repeat (2 * per[c] - 4) @(posedge clock);
			rchk(OFS_T0_STAT, 32'h10000000, 32'h30000000);
			repeat (per[c] + 10) @(posedge clock);
			chk(timer_irq, 2'b01);
			rchk(OFS_IRQ_STAT, 32'h200, 32'hffffffff);
			rchk(OFS_T0_STAT, 32'h21000000 | (32'(c) << 16), 32'hffffffff);
			chk(timer_irq, 2'b00);
		end
		HOST.wr_reg(OFS_T0_CTRL, 32'h0);
		$display("test tick bases done");
		// continuous, irq off, ack on write
		HOST.wr_reg(OFS_GLOBAL_CONTROL, 32'h1);
		HOST.wr_reg(OFS_T1_CTRL, 32'h12030002);
		repeat (100) @(posedge clock);
		rchk(OFS_T1_STAT, 32'h32030000, 32'hffff0000);
		chk(timer_irq, 2'b00);
		rchk(OFS_T1_STAT, 32'h32030000, 32'hffff0000);
		HOST.wr_reg(OFS_T1_CTRL, 32'h02030002);
		HOST.wr_reg(OFS_T1_STAT, 32'h20000000);
		rchk(OFS_T1_STAT, 32'h02030000, 32'hffff0000);
		HOST.restart(OFS_T1_CTRL, 32'h11030002);
		repeat (40) @(posedge clock);
		chk(timer_irq, 2'b10);
		rchk(OFS_IRQ_STAT, 32'h400, 32'hffffffff);
		HOST.wr_reg(OFS_T1_STAT, 32'h0);
		#1 chk(timer_irq, 2'b10);
		HOST.wr_reg(OFS_T1_STAT, 32'h20000000);
		#1 chk(timer_irq, 2'b00);
		HOST.wr_reg(OFS_GLOBAL_CONTROL, 32'h0);
		$display("test continuous done");
		// guard: retrigger, expiry, safe outputs
		HOST.wr_reg(8'h48, 32'ha5);
		rchk(8'h48, 32'ha5, 32'hffffffff);
		HOST.wr_reg(OFS_G_CTRL, 32'h13030002);
		repeat (10) begin
			repeat (8) @(posedge clock);
			HOST.wr_reg(OFS_G_STAT, 32'h0);
			chk(guard_expired, 1'b0);
		end
		repeat (60) @(posedge clock);
		chk(guard_expired, 1'b1);
		chk(guard_irq, 1'b1);
		chk(port_drive, 128'ha5 << 16);
		rchk(OFS_IRQ_STAT, 32'h100, 32'hffffffff);
		rchk(OFS_G_STAT, 32'h13130000, 32'hffffffff);
		chk({guard_irq, guard_expired}, 2'b00);
		@(posedge clock);
		#1 chk(port_drive, PD);
		HOST.wr_reg(OFS_G_CTRL, 32'h0);
		repeat (60) @(posedge clock);
		chk(guard_expired, 1'b0);
		// no safe values, ack on write, then expiry with irq off and disable while expired
		HOST.wr_reg(OFS_GLOBAL_CONTROL, 32'h1);
		HOST.wr_reg(OFS_G_CTRL, 32'h11030002);
		repeat (60) @(posedge clock);
		chk(guard_expired, 1'b1);
		chk(guard_irq, 1'b1);
		chk(port_drive, PD);
		HOST.wr_reg(OFS_G_STAT, 32'h0);
		#1 chk({guard_irq, guard_expired}, 2'b10);
		HOST.wr_reg(OFS_G_STAT, 32'h01000000);
		#1 chk(guard_irq, 1'b0);
		HOST.wr_reg(OFS_G_CTRL, 32'h10030002);
		repeat (60) @(posedge clock);
		chk(guard_expired, 1'b1);
		chk(guard_irq, 1'b0);
		HOST.wr_reg(OFS_G_CTRL, 32'h0);
		repeat (2) @(posedge clock);
		#1 chk(guard_expired, 1'b0);
		HOST.wr_reg(OFS_GLOBAL_CONTROL, 32'h0);
		$display("test guard done");
		final_report();
	end

	// hang guard: tests need well under 20 us
	initial begin
		#100000;
		err_count++;
		final_report();
	end
endmodule

bind dtw_top dtw_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock(clock), .srst(srst),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_data(port_data),
	.port_drive(port_drive), .timer_irq(timer_irq), .guard_irq(guard_irq),
	.guard_expired(guard_expired));
